//--- sspr_host_model.sv
// host serial controller model for the decoder's serial pins
`default_nettype none
module sspr_host_model (
  input wire logic clk_i,
  input wire logic miso_i,
  output sspr_pkg::sspr_spi_in_type spi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx[$];
  logic [7:0] rx;
  initial spi_o = '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // ****
  // one frame: tx bytes, then nrd bytes read, last one kept in rx
  // ****
  task automatic frame(input int nrd);
    logic [7:0] b;
    spi_o.cs_n <= 1'b0;
    tick(4);
    for (int i = 0; i < tx.size() + nrd; i++) begin
      b = (i < tx.size()) ? tx[i] : 8'h00;
      for (int k = 7; k >= 0; k--) begin
        spi_o.mosi <= b[k];
        tick(6);
        spi_o.sck <= 1'b1;
        rx = {rx[6:0], miso_i};
        tick(6);
        spi_o.sck <= 1'b0;
      end
    end
    tick(4);
    spi_o.cs_n <= 1'b1;
    // released data line shows no stale bit
    spi_o.mosi <= ~spi_o.mosi;
    tick(10);
    tx.delete();
  endtask
endmodule
`default_nettype wire

//--- sspr_pkg.sv
// constants and types of the serial sector protection and reset decoder
`default_nettype none
package sspr_pkg;

  // ************************************************************
  // command opcodes
  // ************************************************************
  localparam logic [7:0] READ_DYNAMIC_PROTECT_CMD = 8'he0;
  localparam logic [7:0] WRITE_DYNAMIC_PROTECT_CMD = 8'he1;
  localparam logic [7:0] READ_PERSISTENT_PROTECT_CMD = 8'he2;
  localparam logic [7:0] PROGRAM_PERSISTENT_PROTECT_CMD = 8'he3;
  localparam logic [7:0] ERASE_PERSISTENT_PROTECT_CMD = 8'he4;
  localparam logic [7:0] CLEAR_PROTECT_LOCK_CMD = 8'ha6;
  localparam logic [7:0] READ_PROTECT_LOCK_CMD = 8'ha7;
  localparam logic [7:0] PASSWORD_UNLOCK_CMD = 8'he9;
  localparam logic [7:0] SOFT_RESET_ENABLE_CMD = 8'h66;
  localparam logic [7:0] SOFT_RESET_CMD = 8'h99;
  localparam logic [7:0] ENTER_DEEP_SLEEP_CMD = 8'hb9;
  localparam logic [7:0] WRITE_LATCH_SET_CMD = 8'h06;

  // ************************************************************
  // sector map and framing
  // ************************************************************
  localparam int SECTORS = 16;
  localparam int SECTOR_LSB = 18;
  localparam int SECTOR_BITS = 4;
  localparam logic [1:0] ADDR_LAST = 2'h3;
  localparam logic [2:0] PWD_LAST = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ************************************************************
  // register map, byte offsets
  // ************************************************************
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] PASSWORD_LO_OFS = 8'h08;
  localparam logic [7:0] PASSWORD_HI_OFS = 8'h0c;
  localparam logic [7:0] PERSIST_OFS = 8'h10;
  localparam logic [7:0] DYNAMIC_OFS = 8'h14;
  localparam int ST_WEL = 0;
  localparam int ST_LOCK = 1;
  localparam int ST_LOCKOUT = 2;
  localparam int ST_SLEEP = 3;
  localparam int ST_ARMED = 4;
  localparam int CTL_WAKE = 0;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [63:0] PASSWORD_RESET = 64'hffffffffffffffff;
  localparam logic [SECTORS-1:0] PROTECT_RESET = 16'hffff;
  localparam logic LOCK_RESET = 1'b1;

  typedef enum logic [4:0] {
    ST_CMD = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_DIN = 5'b00100,
    ST_DOUT = 5'b01000,
    ST_SKIP = 5'b10000
  } sspr_state_type;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } sspr_spi_in_type;

endpackage
`default_nettype wire

//--- sspr_top.sv
// serial command decoder for sector protection, soft reset and deep sleep
`default_nettype none
// How it works
// RULE1 - e0 plus four address bytes returns that sector's dynamic byte
// RULE2 - e1 plus address and data writes the sector's dynamic bit
// RULE3 - e2 plus four address bytes returns that sector's persistent byte
// RULE4 - e3 plus address programs that persistent bit to protecting zero
// RULE5 - e4 sets every persistent bit to one
// RULE6 - a6 clears the persistent protection lock bit
// RULE7 - a7 shifts out the eight-bit lock register, msb first
// RULE8 - host sends e9 then eight password bytes, least significant first
// RULE9 - wrong password locks the decoder until hardware reset
// RULE10 - matching password sets the lock bit to one
// RULE11 - 99 acts only when 66 was the transaction just before
// RULE12 - soft reset reloads the write latch, the lock bit and the dynamic bits to their defaults
// RULE13 - b9 enters deep sleep
// RULE14 - 06 sets the write enable latch
// RULE15 - write type commands are ignored while the latch is clear
// RULE16 - any other opcode after 66 disarms the soft reset
// RULE17 - host keeps the serial clock at or below 166 MHz
module sspr_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sspr_pkg::sspr_spi_in_type spi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic soft_reset_o,
  output logic deep_sleep_o
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  sspr_pkg::sspr_spi_in_type sync1;
  sspr_pkg::sspr_spi_in_type sync2;
  logic sck_d;
  logic sck_rise;
  logic sck_fall;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 3'h4;
      sync2 <= 3'h4;
      sck_d <= 1'b0;
    end else begin
      sync1 <= spi_i;
      sync2 <= sync1;
      sck_d <= sync2.sck;
    end
  end

  assign sck_rise = sync2.sck & ~sck_d & ~sync2.cs_n;
  assign sck_fall = ~sync2.sck & sck_d & ~sync2.cs_n;

  // ************************************************************
  // bus registers
  // ************************************************************
  logic [63:0] password;
  logic wake;
  logic bus_hit;
  logic [31:0] next_rdata;
  logic wel;
  logic lock;
  logic lockout;
  logic sleep;
  logic armed;
  logic [sspr_pkg::SECTORS-1:0] persistent_protect_bit;
  logic [sspr_pkg::SECTORS-1:0] dyn;

  assign bus_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_comb begin
    next_rdata = 32'h00000000;
    if (wb_adr_i == sspr_pkg::STATUS_OFS) begin
      next_rdata[sspr_pkg::ST_WEL] = wel;
      next_rdata[sspr_pkg::ST_LOCK] = lock;
      next_rdata[sspr_pkg::ST_LOCKOUT] = lockout;
      next_rdata[sspr_pkg::ST_SLEEP] = sleep;
      next_rdata[sspr_pkg::ST_ARMED] = armed;
    end else if (wb_adr_i == sspr_pkg::PERSIST_OFS) begin
      next_rdata[sspr_pkg::SECTORS-1:0] = persistent_protect_bit;
    end else if (wb_adr_i == sspr_pkg::DYNAMIC_OFS) begin
      next_rdata[sspr_pkg::SECTORS-1:0] = dyn;
    end
  end

  // password words are write only so the hidden value never reads back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      password <= sspr_pkg::PASSWORD_RESET;
      wake <= 1'b0;
    end else begin
      wb_ack_o <= bus_hit;
      wake <= 1'b0;
      if (bus_hit) begin
        wb_dat_o <= wb_we_i ? 32'h00000000 : next_rdata;
      end
      if (bus_hit && wb_we_i) begin
        if (wb_adr_i == sspr_pkg::CONTROL_OFS) begin
          wake <= wb_sel_i[0] & wb_dat_i[sspr_pkg::CTL_WAKE];
        end else if (wb_adr_i == sspr_pkg::PASSWORD_LO_OFS) begin
          for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
              password[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
            end
          end
        end else if (wb_adr_i == sspr_pkg::PASSWORD_HI_OFS) begin
          for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
              password[32+i*8 +: 8] <= wb_dat_i[i*8 +: 8];
            end
          end
        end
      end
    end
  end

  // ************************************************************
  // serial framing
  // ************************************************************
  sspr_pkg::sspr_state_type state;
  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [7:0] opcode;
  logic [2:0] byte_cnt;
  logic [23:0] addr;
  logic [sspr_pkg::SECTOR_BITS-1:0] sector;
  logic [31:0] full_addr;
  logic [63:0] pwd_shift;
  logic [63:0] next_pwd;
  logic [7:0] out_byte;
  logic [7:0] out_shift;
  logic needs_wel;

  assign rx_byte = {shift_in, sync2.mosi};
  assign byte_done = sck_rise && (bit_cnt == sspr_pkg::BIT_LAST);
  assign full_addr = {addr, rx_byte};
  assign next_pwd = {rx_byte, pwd_shift[63:8]};
  assign needs_wel = (rx_byte == sspr_pkg::WRITE_DYNAMIC_PROTECT_CMD) ||
    (rx_byte == sspr_pkg::PROGRAM_PERSISTENT_PROTECT_CMD) ||
    (rx_byte == sspr_pkg::ERASE_PERSISTENT_PROTECT_CMD) ||
    (rx_byte == sspr_pkg::CLEAR_PROTECT_LOCK_CMD);

  always_ff @(posedge clk_i) begin
    if (rst_i || sync2.cs_n) begin
      bit_cnt <= 3'h0;
      shift_in <= 7'h00;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift_in <= rx_byte[6:0];
    end
  end

  // ************************************************************
  // command decode and protection state
  // ************************************************************
  // one process owns all protection bits so soft reset has one driver
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= sspr_pkg::ST_CMD;
      opcode <= 8'h00;
      byte_cnt <= 3'h0;
      addr <= 24'h000000;
      sector <= '0;
      pwd_shift <= 64'h0000000000000000;
      out_byte <= 8'h00;
      wel <= 1'b0;
      lock <= sspr_pkg::LOCK_RESET;
      lockout <= 1'b0;
      sleep <= 1'b0;
      armed <= 1'b0;
      persistent_protect_bit <= sspr_pkg::PROTECT_RESET;
      dyn <= sspr_pkg::PROTECT_RESET;
      soft_reset_o <= 1'b0;
    end else begin
      soft_reset_o <= 1'b0;
      if (wake) begin
        sleep <= 1'b0;
      end
      if (sync2.cs_n) begin
        state <= sspr_pkg::ST_CMD;
        byte_cnt <= 3'h0;
      end else if (byte_done) begin
        case (state)
          sspr_pkg::ST_CMD: begin
            opcode <= rx_byte;
            byte_cnt <= 3'h0;
            state <= sspr_pkg::ST_SKIP;
            if (!lockout && !sleep) begin // RULE9
              armed <= (rx_byte == sspr_pkg::SOFT_RESET_ENABLE_CMD); // RULE16
              if (needs_wel && !wel) begin
                state <= sspr_pkg::ST_SKIP; // RULE15
              end else if (rx_byte == sspr_pkg::READ_DYNAMIC_PROTECT_CMD ||
                  rx_byte == sspr_pkg::WRITE_DYNAMIC_PROTECT_CMD ||
                  rx_byte == sspr_pkg::READ_PERSISTENT_PROTECT_CMD ||
                  rx_byte == sspr_pkg::PROGRAM_PERSISTENT_PROTECT_CMD) begin
                state <= sspr_pkg::ST_ADDR;
                if (needs_wel) begin
                  wel <= 1'b0;
                end
              end else if (rx_byte == sspr_pkg::ERASE_PERSISTENT_PROTECT_CMD) begin
                persistent_protect_bit <= '1; // RULE5
                wel <= 1'b0;
              end else if (rx_byte == sspr_pkg::CLEAR_PROTECT_LOCK_CMD) begin
                lock <= 1'b0; // RULE6
                wel <= 1'b0;
              end else if (rx_byte == sspr_pkg::READ_PROTECT_LOCK_CMD) begin
                out_byte <= {7'h00, lock}; // RULE7
                state <= sspr_pkg::ST_DOUT;
              end else if (rx_byte == sspr_pkg::PASSWORD_UNLOCK_CMD) begin
                state <= sspr_pkg::ST_DIN; // RULE8
              end else if (rx_byte == sspr_pkg::WRITE_LATCH_SET_CMD) begin
                wel <= 1'b1; // RULE14
              end else if (rx_byte == sspr_pkg::ENTER_DEEP_SLEEP_CMD) begin
                sleep <= 1'b1; // RULE13
              end else if (rx_byte == sspr_pkg::SOFT_RESET_CMD && armed) begin
                // RULE11
                wel <= 1'b0; // RULE12
                lock <= sspr_pkg::LOCK_RESET;
                dyn <= sspr_pkg::PROTECT_RESET;
                soft_reset_o <= 1'b1;
              end
            end
          end
          sspr_pkg::ST_ADDR: begin
            addr <= full_addr[23:0];
            byte_cnt <= byte_cnt + 3'h1;
            if (byte_cnt[1:0] == sspr_pkg::ADDR_LAST) begin
              sector <= full_addr[sspr_pkg::SECTOR_LSB +: sspr_pkg::SECTOR_BITS];
              byte_cnt <= 3'h0;
              state <= sspr_pkg::ST_SKIP;
              if (opcode == sspr_pkg::READ_DYNAMIC_PROTECT_CMD) begin
                // RULE1
                out_byte <= {8{dyn[full_addr[sspr_pkg::SECTOR_LSB +:
                  sspr_pkg::SECTOR_BITS]]}};
                state <= sspr_pkg::ST_DOUT;
              end else if (opcode == sspr_pkg::READ_PERSISTENT_PROTECT_CMD) begin
                // RULE3
                out_byte <= {8{persistent_protect_bit[full_addr[sspr_pkg::SECTOR_LSB +:
                  sspr_pkg::SECTOR_BITS]]}};
                state <= sspr_pkg::ST_DOUT;
              end else if (opcode == sspr_pkg::WRITE_DYNAMIC_PROTECT_CMD) begin
                state <= sspr_pkg::ST_DIN;
              end else begin
                persistent_protect_bit[full_addr[sspr_pkg::SECTOR_LSB +:
                  sspr_pkg::SECTOR_BITS]] <= 1'b0; // RULE4
              end
            end
          end
          sspr_pkg::ST_DIN: begin
            if (opcode == sspr_pkg::WRITE_DYNAMIC_PROTECT_CMD) begin
              dyn[sector] <= rx_byte[0]; // RULE2
            end else begin
              pwd_shift <= next_pwd; // RULE8
              byte_cnt <= byte_cnt + 3'h1;
              if (byte_cnt == sspr_pkg::PWD_LAST) begin
                state <= sspr_pkg::ST_SKIP;
                if (next_pwd == password) begin
                  lock <= 1'b1; // RULE10
                end else begin
                  lockout <= 1'b1; // RULE9
                end
              end
            end
          end
          sspr_pkg::ST_DOUT: begin
            state <= sspr_pkg::ST_DOUT;
          end
          default: begin
            state <= sspr_pkg::ST_SKIP;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // serial output, mode 0: change on falling edge
  // ************************************************************
  // the same byte repeats for as long as the host keeps clocking
  always_ff @(posedge clk_i) begin
    if (rst_i || sync2.cs_n || state != sspr_pkg::ST_DOUT) begin
      out_shift <= out_byte;
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end else if (sck_fall) begin
      miso_oe_o <= 1'b1;
      // first bit of a byte comes from out_byte, the shifter may be stale
      miso_o <= (bit_cnt == 3'h0) ? out_byte[7] : out_shift[7];
      out_shift <= (bit_cnt == 3'h0) ? {out_byte[6:0], out_byte[7]} :
        {out_shift[6:0], out_shift[7]};
    end
  end

  assign deep_sleep_o = sleep;

endmodule
`default_nettype wire

//--- sspr_top_assertions.sv
// port checker for the protection and reset decoder
`default_nettype none
module sspr_top_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sspr_pkg::sspr_spi_in_type spi_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic soft_reset_o,
  input wire logic deep_sleep_o
);
  logic req;
  logic wake;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // wake stays true over the ack cycle, so a late fall still matches
  assign wake = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
    && wb_dat_i[0] && wb_adr_i == sspr_pkg::CONTROL_OFS;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // properties
  // ****
  ack_answer_a: assert property (req |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  reset_pulse_a: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset pulse too long");
  sleep_hold_a: assert property (deep_sleep_o && !wake |=> deep_sleep_o)
    else $error("deep sleep left without wake");
  wake_cause_a: assert property ($fell(deep_sleep_o) |->
    $past(wake) || $past(wake, 2)) else $error("sleep fell with no wake");
  sleep_status_a: assert property (req && !wb_we_i &&
    wb_adr_i == sspr_pkg::STATUS_OFS |=>
    wb_dat_o[sspr_pkg::ST_SLEEP] == $past(deep_sleep_o))
    else $error("status sleep bit wrong");
  miso_idle_a: assert property (spi_i.cs_n [*5] |-> !miso_oe_o)
    else $error("miso driven while deselected");
  miso_steady_a: assert property (miso_oe_o && spi_i.sck &&
    $past(spi_i.sck) |-> $stable(miso_o)) else $error("miso moved in high");
  soft_c: cover property (soft_reset_o);
  sleep_c: cover property ($rose(deep_sleep_o));
  read_c: cover property (miso_oe_o && spi_i.sck);
endmodule
bind sspr_top sspr_top_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .spi_i(spi_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .soft_reset_o(soft_reset_o), .deep_sleep_o(deep_sleep_o));
`default_nettype wire

//--- test_spi_sector_protect_reset_cmds.sv
// self-checking bench for the protection and reset decoder
`default_nettype none
module test_spi_sector_protect_reset_cmds;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b1;
  logic miso, oe, ack, srst, sleep;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [63:0] pwd;
  sspr_pkg::sspr_spi_in_type spi;
  int fail_count = 0, n_compared = 0, cyc_n = 0, resets = 0;
  int wel = 0, lock = 1, lko = 0, slp = 0, arm = 0;
  int pers = 'hffff, dyn = 'hffff;
  initial forever #12.5 clk_i = ~clk_i;
  sspr_host_model host_u (.clk_i(clk_i), .miso_i(miso), .spi_o(spi));
  sspr_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .spi_i(spi),
    .miso_o(miso), .miso_oe_o(oe), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i({4{sel}}), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .soft_reset_o(srst),
    .deep_sleep_o(sleep));
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (srst === 1'b1) resets <= resets + 1;
    if (cyc_n == 40000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input int d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  function automatic logic [31:0] st();
    return {27'h0, arm[0], slp[0], lko[0], lock[0], wel[0]};
  endfunction
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 0);
    chk("register", e, rd);
  endtask
  // ****
  // one command frame, bench model updated from its opcode
  // ****
  task automatic send(logic [7:0] c, int s = 0, logic [63:0] d = 0,
      int n = 0);
    logic [31:0] a;
    a = (s << sspr_pkg::SECTOR_LSB) | ($urandom & 32'h3ffff);
    host_u.tx = {c};
    if (c inside {8'he0, 8'he1, 8'he2, 8'he3})
      host_u.tx = {c, a[31:24], a[23:16], a[15:8], a[7:0]};
    if (c == 8'he1) host_u.tx.push_back(d[7:0]);
    if (c == 8'he9) for (int i = 0; i < 8; i++)
      host_u.tx.push_back(d[8*i +: 8]);
    host_u.frame(n);
    if (lko || slp) return;
    if (c == 8'h99 && arm) {wel, lock, dyn} = {32'h0, 32'h1, 32'hffff};
    arm = (c == 8'h66);
    if (c == 8'h06) wel = 1;
    if (c == 8'hb9) slp = 1;
    if (c == 8'he9 && d == pwd) lock = 1;
    if (c == 8'he9 && d != pwd) lko = 1;
    if (!wel || !(c inside {8'he1, 8'he3, 8'he4, 8'ha6})) return;
    wel = 0;
    if (c == 8'he1) dyn[s] = d[0];
    if (c == 8'he3) pers[s] = 1'b0;
    if (c == 8'he4) pers = 'hffff;
    if (c == 8'ha6) lock = 0;
  endtask
  task automatic chk_spi(input logic [7:0] c, input int s, e);
    send(c, s, 0, 2);
    chk("serial byte", e, {24'h0, host_u.rx});
    chk("miso enable", 0, oe);
  endtask
  initial begin
    pwd = {$urandom(13), $urandom};
    pwd = {$urandom, $urandom};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk_reg(sspr_pkg::STATUS_OFS, st());
    chk_reg(sspr_pkg::PERSIST_OFS, pers);
    chk_reg(8'h20, 0);
    wb(1'b1, sspr_pkg::PASSWORD_LO_OFS, pwd[31:0]);
    wb(1'b1, sspr_pkg::PASSWORD_HI_OFS, pwd[63:32]);
    send(8'he3, 5);
    chk_reg(sspr_pkg::PERSIST_OFS, pers);
    send(8'h06);
    chk_reg(sspr_pkg::STATUS_OFS, st());
    send(8'he3, 5);
    chk_reg(sspr_pkg::PERSIST_OFS, pers);
    chk_spi(8'he2, 5, {8{pers[5]}});
    chk_spi(8'he2, 6, {8{pers[6]}});
    send(8'h06);
    send(8'he1, 3, 64'hfe);
    chk_spi(8'he0, 3, {8{dyn[3]}});
    send(8'h06);
    send(8'he4);
    chk_reg(sspr_pkg::PERSIST_OFS, pers);
    send(8'h06);
    send(8'ha6);
    chk_spi(8'ha7, 0, lock);
    send(8'he9, 0, pwd);
    chk_spi(8'ha7, 0, lock);
    send(8'h66);
    chk_reg(sspr_pkg::STATUS_OFS, st());
    send(8'h06);
    send(8'h99);
    chk_reg(sspr_pkg::DYNAMIC_OFS, dyn);
    send(8'h66);
    send(8'h99);
    chk_reg(sspr_pkg::DYNAMIC_OFS, dyn);
    chk_reg(sspr_pkg::STATUS_OFS, st());
    chk("soft reset pulses", 1, resets);
    send(8'hb9);
    chk("deep sleep", slp, sleep);
    send(8'h06);
    chk_reg(sspr_pkg::STATUS_OFS, st());
    wb(1'b1, sspr_pkg::CONTROL_OFS, 1);
    slp = 0;
    send(8'he9, 0, ~pwd);
    chk("deep sleep", slp, sleep);
    send(8'h06);
    chk_reg(sspr_pkg::STATUS_OFS, st());
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    {wel, lock, lko, arm} = {32'h0, 32'h1, 64'h0};
    chk_reg(sspr_pkg::STATUS_OFS, st());
    finish_test();
  end
endmodule
`default_nettype wire
